/* dv/serial_host_model.sv */
// host side of the three-wire load: link clock, data and strobe
// assumes the bench calls send from its main sequence
`timescale 1ns/1ns
`default_nettype none
module serial_host_model (
   output logic link_clk,
   output logic serial_data,
   output logic latch_strobe
);
   // ---------------------------------
   // frame driver
   // ---------------------------------
   // idle pins
   initial begin
      link_clk = 1'b0;
      serial_data = 1'b0;
      latch_strobe = 1'b0;
   end
   // shift n bits msb first at 160 ns, clock still outside the frame
   task send(input logic [31:0] w, input int n);
      #37;
      for (int i = n - 1; i >= 0; i--) begin
         serial_data = w[i];
         #80 link_clk = 1'b1;
         #80 link_clk = 1'b0;
      end
      // released data line shows the inverse of the last bit
      serial_data = ~serial_data;
      #100 latch_strobe = 1'b1;
      #100 latch_strobe = 1'b0;
   endtask
endmodule
`default_nettype wire

/* dv/synth_serial_regs_chk.sv */
// assertions on the register bank pins
// assumes binding to synth_serial_regs
`timescale 1ns/1ns
`default_nettype none
module synth_serial_regs_chk (
   input wire logic sys_clk,
   input wire logic nrst,
   input wire logic latch_strobe,
   input wire logic [10:0] rf_int_divide,
   input wire logic [11:0] rf_frac_numerator,
   input wire synth_serial_pkg::int_divide_type rf_counts,
   input wire logic rf_prescaler_select,
   input wire logic [10:0] rf_divide_value,
   input wire logic modulator_owns_b_bit,
   input wire logic lock_counters_reset,
   input wire logic word_written
);
   // ---------------------------------
   // properties
   // ---------------------------------
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!nrst);
   // one-cycle load pulse
   sequence load_s;
      word_written ##1 !word_written;
   endsequence
   AST_PULSE: assert property (word_written |-> load_s)
      else $error("load pulse too long");
   AST_LATCH: assert property ($rose(latch_strobe) |-> ##[3:9] load_s)
      else $error("strobe gave no load");
   AST_RFWR: assert property (lock_counters_reset |-> word_written)
      else $error("lock reset without load");
   AST_ONEW: assert property ($changed({rf_int_divide, rf_frac_numerator}) |-> lock_counters_reset)
      else $error("divider moved without word zero load");
   AST_DEC: assert property ($changed(rf_prescaler_select) |-> word_written && !lock_counters_reset)
      else $error("prescaler select moved wrongly");
   AST_SPLIT: assert property (rf_counts == rf_int_divide)
      else $error("count split wrong");
   AST_DIV: assert property (rf_divide_value == 11'((rf_prescaler_select ? 16 : 8) * rf_counts.cycle_count
      + 4 * rf_counts.b_count + rf_counts.a_count))
      else $error("divide value wrong");
   AST_OWNB: assert property (modulator_owns_b_bit == (!rf_prescaler_select && rf_counts.b_count < 2'h2))
      else $error("b bit ownership wrong");
endmodule
bind synth_serial_regs synth_serial_regs_chk chk (
   .sys_clk(sys_clk),
   .nrst(nrst),
   .latch_strobe(latch_strobe),
   .rf_int_divide(rf_int_divide),
   .rf_frac_numerator(rf_frac_numerator),
   .rf_counts(rf_counts),
   .rf_prescaler_select(rf_prescaler_select),
   .rf_divide_value(rf_divide_value),
   .modulator_owns_b_bit(modulator_owns_b_bit),
   .lock_counters_reset(lock_counters_reset),
   .word_written(word_written)
);
`default_nettype wire

/* dv/synth_serial_regs_tb.sv */
// bench for the serial register bank
// assumes the host model drives the three-wire pins
`timescale 1ns/1ns
`default_nettype none
module synth_serial_regs_tb;
   logic sys_clk = 1'b0;
   logic nrst;
   logic link_clk, serial_data, latch_strobe;
   logic [2:0] word_sel = 3'h0;
   logic [23:0] word_data;
   logic [10:0] rf_int_divide, rf_divide_value;
   logic [11:0] rf_frac_numerator;
   synth_serial_pkg::int_divide_type rf_counts;
   logic rf_prescaler_select, modulator_owns_b_bit, lock_counters_reset, word_written;
   logic [1:0] modulator_order;
   int bad_count = 0, total_checks = 0, wcnt = 0, lcnt = 0, cyc = 0;
   // ---------------------------------
   // harness
   // ---------------------------------
   always #5 sys_clk = ~sys_clk;
   serial_host_model host (
      .link_clk(link_clk),
      .serial_data(serial_data),
      .latch_strobe(latch_strobe)
   );
   synth_serial_regs dut (
      .sys_clk(sys_clk),
      .nrst(nrst),
      .link_clk(link_clk),
      .serial_data(serial_data),
      .latch_strobe(latch_strobe),
      .word_sel(word_sel),
      .word_data(word_data),
      .rf_int_divide(rf_int_divide),
      .rf_frac_numerator(rf_frac_numerator),
      .rf_counts(rf_counts),
      .rf_prescaler_select(rf_prescaler_select),
      .modulator_order(modulator_order),
      .rf_divide_value(rf_divide_value),
      .modulator_owns_b_bit(modulator_owns_b_bit),
      .lock_counters_reset(lock_counters_reset),
      .word_written(word_written)
   );
   // count load pulses and cut a hang short
   always @(posedge sys_clk) begin
      if (word_written === 1'b1) wcnt <= wcnt + 1;
      if (lock_counters_reset === 1'b1) lcnt <= lcnt + 1;
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         bad_count++;
         summarize();
      end
   end
   // compare one value
   task chk(input string s, input logic [23:0] e, input logic [23:0] g);
      total_checks++;
      if (g !== e) begin
         bad_count++;
         $display("unexpected %s exp %h got %h", s, e, g);
      end
   endtask
   // load one word and look at the stored copy
   task wr(input logic [2:0] idx, input logic [31:0] w, input int n);
      int ew, el;
      ew = wcnt + 1;
      el = lcnt + int'(idx == 3'h0);
      host.send(w, n);
      for (int i = 0; i < 20 && wcnt != ew; i++) @(posedge sys_clk);
      chk("loads", 24'(ew), 24'(wcnt));
      chk("rf loads", 24'(el), 24'(lcnt));
      @(posedge sys_clk);
      word_sel <= idx;
      repeat (3) @(posedge sys_clk);
      chk("word", w[23:0], word_data);
   endtask
   // verdict and end of run
   task summarize();
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   // ---------------------------------
   // main sequence
   // ---------------------------------
   initial begin
      nrst <= 1'b0;
      repeat (3) @(posedge sys_clk);
      nrst <= 1'b1;
      wr(3'h1, 32'h400003, 24);
      chk("presel", 24'h1, 24'(rf_prescaler_select));
      wr(3'h4, 32'h208009, 24);
      chk("order", 24'h2, 24'(modulator_order));
      for (int k = 2; k < 7; k++) if (k != 4) wr(3'(k), 32'hC35A50 | 32'(2 * k + 1), 24);
      wr(3'h7, 32'h00090F, 24);
      wr(3'h0, {8'h0, 11'h037, 12'hABC, 1'b0}, 24);
      chk("int", 24'h037, 24'(rf_int_divide));
      chk("frac", 24'hABC, 24'(rf_frac_numerator));
      chk("cycle", 24'h3, 24'(rf_counts.cycle_count));
      chk("divide", 24'h037, 24'(rf_divide_value));
      chk("own b", 24'h0, 24'(modulator_owns_b_bit));
      wr(3'h1, 32'h000003, 24);
      chk("divide", 24'h01F, 24'(rf_divide_value));
      chk("own b", 24'h1, 24'(modulator_owns_b_bit));
      // eight-based, order two: divide 26 with C=3, B=0, A=2
      wr(3'h0, {8'h0, 11'h032, 12'h001, 1'b0}, 24);
      chk("divide", 24'h01A, 24'(rf_divide_value));
      chk("own b", 24'h1, 24'(modulator_owns_b_bit));
      wr(3'h0, {4'h0, 4'hF, 11'h7F7, 12'h807, 1'b0}, 28);
      chk("int", 24'h7F7, 24'(rf_int_divide));
      chk("frac", 24'h807, 24'(rf_frac_numerator));
      chk("divide", 24'h3FF, 24'(rf_divide_value));
      summarize();
   end
endmodule
`default_nettype wire

/* rtl/synth_serial_pkg.sv */
// package for the serial-programmed synthesizer register bank
// shared by the register bank top, its checker and its bench
package synth_serial_pkg;

   // ----------------------------------------------------------------------
   // word geometry
   // ----------------------------------------------------------------------
   localparam int WORD_BITS = 24;
   localparam int WORD_COUNT = 8;
   localparam int CNT_BITS = 5;

   // ----------------------------------------------------------------------
   // address decode
   // ----------------------------------------------------------------------
   localparam logic [3:0] CODE_RF_DEN = 4'h3;
   localparam logic [3:0] CODE_IF_DIV = 4'h5;
   localparam logic [3:0] CODE_IF_GAIN = 4'h7;
   localparam logic [3:0] CODE_MISC = 4'h9;
   localparam logic [3:0] CODE_FRAC_EXT = 4'hB;
   localparam logic [3:0] CODE_FAST_LOCK = 4'hD;
   localparam logic [3:0] CODE_TEST_RESET = 4'hF;
   localparam logic [2:0] IDX_RF_DIVIDER = 3'h0;

   // ----------------------------------------------------------------------
   // rf divider word field positions, prescaler select and modulator order bits
   // ----------------------------------------------------------------------
   localparam int FRAC_LSB = 1;
   localparam int FRAC_MSB = 12;
   localparam int INT_LSB = 13;
   localparam int INT_MSB = 23;
   localparam int A_LSB = 0;
   localparam int B_LSB = 2;
   localparam int C_LSB = 4;
   localparam int PRESEL_BIT = 22; // prescaler select inside rf_ref_denominator_word
   localparam int ORDER_LSB = 14; // modulator_order inside misc_config_word
   localparam int ORDER_MSB = 15;
   localparam logic [23:0] WORD_RESET = 24'h000000;

   // prescaler bases
   localparam logic [4:0] BASE_EIGHT = 5'h08;
   localparam logic [4:0] BASE_SIXTEEN = 5'h10;

   typedef struct packed {
      logic [6:0] cycle_count;
      logic [1:0] b_count;
      logic [1:0] a_count;
   } int_divide_type;

   typedef struct packed {
      logic valid; // one-cycle pulse in the system domain
      logic [2:0] index;
      logic [WORD_BITS-1:0] data;
   } load_type;

endpackage

/* rtl/synth_serial_regs.sv */
// serial register bank of a dual synthesizer: three-wire load, decode, rf divider fields
// assumes link clock runs only while the host shifts; latch_strobe is a pin
`timescale 1ns/1ns
`default_nettype none
module synth_serial_regs #(
   parameter int WORD_BITS = synth_serial_pkg::WORD_BITS
) (
   input wire logic sys_clk,
   input wire logic nrst,
   input wire logic link_clk,
   input wire logic serial_data,
   input wire logic latch_strobe,
   input wire logic [2:0] word_sel,
   output logic [WORD_BITS-1:0] word_data,
   output logic [10:0] rf_int_divide,
   output logic [11:0] rf_frac_numerator,
   output synth_serial_pkg::int_divide_type rf_counts,
   output logic rf_prescaler_select,
   output logic [1:0] modulator_order,
   output logic [10:0] rf_divide_value,
   output logic modulator_owns_b_bit,
   output logic lock_counters_reset,
   output logic word_written
);

   // ----------------------------------------------------------------------
   // link domain: shift register on the serial clock
   // ----------------------------------------------------------------------
   typedef struct packed {
      logic [WORD_BITS-1:0] shift;
   } link_state_type;

   link_state_type link_q, link_d;

   // msb first: each rising link edge pushes the new bit into the low end
   always_comb begin
      link_d = link_q;
      link_d.shift = {link_q.shift[WORD_BITS-2:0], serial_data};
   end

   always_ff @(posedge link_clk or negedge nrst) begin
      if (!nrst) begin
         link_q <= '0;
      end else begin
         link_q <= link_d;
      end
   end

   // ----------------------------------------------------------------------
   // system domain state
   // ----------------------------------------------------------------------
   typedef struct packed {
      logic strobe_meta;
      logic strobe_sync;
      logic strobe_prev;
      logic capture_wait;
      logic [WORD_BITS-1:0] word_meta;
      logic [WORD_BITS-1:0] word_sync;
      synth_serial_pkg::load_type load;
      logic lock_reset;
      logic [11:0] frac;
      logic [10:0] int_div;
      logic presel;
      logic [1:0] order;
   } sys_state_type;

   sys_state_type sys_q, sys_d;
   logic [3:0] code;
   logic [2:0] target;
   logic [4:0] base;
   logic [11:0] div_sum;

   // decode the low control bits of the captured word
   always_comb begin
      code = sys_q.word_sync[3:0];
      target = synth_serial_pkg::IDX_RF_DIVIDER;
      if (code[0] == 1'b0) begin
         target = synth_serial_pkg::IDX_RF_DIVIDER;
      end else if (code == synth_serial_pkg::CODE_RF_DEN) begin
         target = 3'h1;
      end else if (code == synth_serial_pkg::CODE_IF_DIV) begin
         target = 3'h2;
      end else if (code == synth_serial_pkg::CODE_IF_GAIN) begin
         target = 3'h3;
      end else if (code == synth_serial_pkg::CODE_MISC) begin
         target = 3'h4;
      end else if (code == synth_serial_pkg::CODE_FRAC_EXT) begin
         target = 3'h5;
      end else if (code == synth_serial_pkg::CODE_FAST_LOCK) begin
         target = 3'h6;
      end else begin
         target = 3'h7;
      end
   end

   // strobe synchroniser, word capture and field update
   always_comb begin
      sys_d = sys_q;
      sys_d.strobe_meta = latch_strobe;
      sys_d.strobe_sync = sys_q.strobe_meta;
      sys_d.strobe_prev = sys_q.strobe_sync;
      // the shift register is quiet once the strobe rises; sample it twice then
      sys_d.word_meta = link_q.shift;
      sys_d.word_sync = sys_q.word_meta;
      sys_d.load.valid = 1'b0;
      sys_d.lock_reset = 1'b0;
      sys_d.capture_wait = 1'b0;
      if (sys_q.strobe_sync && !sys_q.strobe_prev) begin
         sys_d.capture_wait = 1'b1;
      end
      if (sys_q.capture_wait) begin
         sys_d.load.valid = 1'b1;
         sys_d.load.index = target;
         sys_d.load.data = sys_q.word_sync;
         if (target == synth_serial_pkg::IDX_RF_DIVIDER) begin
            sys_d.lock_reset = 1'b1;
            sys_d.frac = sys_q.word_sync[synth_serial_pkg::FRAC_MSB:synth_serial_pkg::FRAC_LSB];
            sys_d.int_div = sys_q.word_sync[synth_serial_pkg::INT_MSB:synth_serial_pkg::INT_LSB];
         end else if (target == 3'h1) begin
            sys_d.presel = sys_q.word_sync[synth_serial_pkg::PRESEL_BIT];
         end else if (target == 3'h4) begin
            // fixed bits are stored as written; host keeps them exact
            sys_d.order = sys_q.word_sync[synth_serial_pkg::ORDER_MSB:synth_serial_pkg::ORDER_LSB];
         end
      end
   end

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         sys_q <= '0;
      end else begin
         sys_q <= sys_d;
      end
   end

   // ----------------------------------------------------------------------
   // word store, read through word_sel onto the word_data output
   // ----------------------------------------------------------------------
   synth_word_store #(
      .WIDTH(WORD_BITS),
      .DEPTH(synth_serial_pkg::WORD_COUNT)
   ) u_store (
      .sys_clk(sys_clk),
      .nrst(nrst),
      .wr_en(sys_q.load.valid),
      .wr_index(sys_q.load.index),
      .wr_data(sys_q.load.data),
      .rd_index(word_sel),
      .rd_data(word_data)
   );

   // ----------------------------------------------------------------------
   // divider fields and divide value
   // ----------------------------------------------------------------------
   assign rf_int_divide = sys_q.int_div;
   assign rf_frac_numerator = sys_q.frac;
   assign rf_counts = synth_serial_pkg::int_divide_type'(sys_q.int_div);
   assign rf_prescaler_select = sys_q.presel;
   assign modulator_order = sys_q.order;
   assign base = sys_q.presel ? synth_serial_pkg::BASE_SIXTEEN : synth_serial_pkg::BASE_EIGHT;

   // base times C plus four B plus A; host keeps it in the legal range
   always_comb begin
      div_sum = 12'(base * rf_counts.cycle_count) + 12'({rf_counts.b_count, 2'b00})
         + 12'(rf_counts.a_count);
   end
   assign rf_divide_value = div_sum[10:0];

   // eight-based set uses 4B with B below 2 leaving its top bit free
   assign modulator_owns_b_bit = !sys_q.presel && !rf_counts.b_count[1];
   assign lock_counters_reset = sys_q.lock_reset;
   assign word_written = sys_q.load.valid;

endmodule
`default_nettype wire

/* rtl/synth_word_store.sv */
// eight-entry store of programmed words with a registered read port
// assumes writes and reads arrive on sys_clk
`timescale 1ns/1ns
`default_nettype none
module synth_word_store #(
   parameter int WIDTH = 24,
   parameter int DEPTH = 8
) (
   input wire logic sys_clk,
   input wire logic nrst,
   input wire logic wr_en,
   input wire logic [$clog2(DEPTH)-1:0] wr_index,
   input wire logic [WIDTH-1:0] wr_data,
   input wire logic [$clog2(DEPTH)-1:0] rd_index,
   output logic [WIDTH-1:0] rd_data
);
   logic [WIDTH-1:0] mem_q [DEPTH];

   // one generate entry per word
   genvar gi;
   for (gi = 0; gi < DEPTH; gi++) begin : g_word
      always_ff @(posedge sys_clk or negedge nrst) begin
         if (!nrst) begin
            mem_q[gi] <= '0;
         end else if (wr_en && wr_index == ($clog2(DEPTH))'(gi)) begin
            mem_q[gi] <= wr_data;
         end
      end
   end

   // registered read
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         rd_data <= '0;
      end else begin
         rd_data <= mem_q[rd_index];
      end
   end
endmodule
`default_nettype wire
